// ==== src/rsa_core.sv ====
/*
 rotate-right and borrow-subtract datapath slice with accumulator and flags.
 assumes the decoder pulses op_in for one cycle with the memory byte on mem_in;
 memory writes leave through mem_we_out / mem_out.
*/
`timescale 1ns/100ps
module rsa_core
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [5:0] op_in,
	input wire logic [7:0] mem_in,
	output logic [7:0] acc_out,
	output logic [5:0] flags_out,
	output logic [7:0] mem_out,
	output logic mem_we_out
);
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic [5:0] flags_q;
	logic [5:0] flags_d;
	logic [7:0] mem_q;
	logic [7:0] mem_d;
	logic we_q;
	logic we_d;
	logic carry_now;
	logic [5:0] op_eff;
	logic [5:0] sub_flags;
	rsa_res_if res ();

	// fill bit enters at the top, bit 0 drops out
	function automatic logic [7:0] rot_right(input logic fill, input logic [7:0] byte_in);
		return {fill, byte_in[7:1]};
	endfunction

	// only a single set bit other than the idle code counts as an operation
	function automatic logic op_known(input logic [5:0] op);
		return $onehot(op) && (op != rsa_pkg::RSA_OP_NONE);
	endfunction

	function automatic logic is_sub(input logic [5:0] op);
		return (op == rsa_pkg::RSA_OP_SUB_ACC) || (op == rsa_pkg::RSA_OP_SUB_MEM);
	endfunction

	function automatic logic is_rot_carry(input logic [5:0] op);
		return (op == rsa_pkg::RSA_OP_ROT_CARRY) || (op == rsa_pkg::RSA_OP_ROT_CARRY_ACC);
	endfunction

	// chained null folds in the earlier result so multi-byte compares work
	function automatic logic [5:0] sub_flag_vec(input logic [5:0] prev, input logic [7:0] diff,
		input logic carry, input logic half, input logic wrap, input logic zero);
		logic [5:0] v;
		v = prev;
		v[rsa_pkg::F_CARRY] = carry;
		v[rsa_pkg::F_HALF] = half;
		v[rsa_pkg::F_ZERO] = zero;
		v[rsa_pkg::F_WRAP] = wrap;
		v[rsa_pkg::F_CSIGN] = diff[7] ^ wrap;
		v[rsa_pkg::F_CNULL] = zero & prev[rsa_pkg::F_CNULL];
		return v;
	endfunction

	rsa_sub u_sub
	(
		.acc_in(acc_q),
		.opd_in(mem_in),
		.carry_in(carry_now),
		.res(res)
	);

	assign carry_now = flags_q[rsa_pkg::F_CARRY];
	// refused codes collapse to idle here so no branch below can see them
	assign op_eff = op_known(op_in) ? op_in : rsa_pkg::RSA_OP_NONE;
	assign sub_flags = sub_flag_vec(flags_q, res.diff, res.carry, res.half, res.wrap, res.zero);

	// accumulator
	always_comb
	begin
		acc_d = acc_q;
		case (op_eff)
			rsa_pkg::RSA_OP_ROT_ACC:
			begin
				acc_d = rot_right(mem_in[0], mem_in);
			end
			rsa_pkg::RSA_OP_ROT_CARRY_ACC:
			begin
				acc_d = rot_right(carry_now, mem_in);
			end
			rsa_pkg::RSA_OP_SUB_ACC:
			begin
				acc_d = res.diff;
			end
			rsa_pkg::RSA_OP_ROT_CARRY, rsa_pkg::RSA_OP_SUB_MEM:
			begin
				acc_d = acc_q;
			end
			default:
			begin
				acc_d = acc_q;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			acc_q <= rsa_pkg::ACC_RST;
		end
		else
		begin
			acc_q <= acc_d;
		end
	end

	// flags: the plain rotate must leave all six alone
	always_comb
	begin
		flags_d = flags_q;
		case (op_eff)
			rsa_pkg::RSA_OP_ROT_ACC:
			begin
				flags_d = flags_q;
			end
			rsa_pkg::RSA_OP_ROT_CARRY, rsa_pkg::RSA_OP_ROT_CARRY_ACC:
			begin
				flags_d[rsa_pkg::F_CARRY] = mem_in[0];
			end
			rsa_pkg::RSA_OP_SUB_ACC:
			begin
				flags_d = sub_flags;
			end
			rsa_pkg::RSA_OP_SUB_MEM:
			begin
				// same flag set as the acc form; one path, no second subtractor
				flags_d = sub_flags;
			end
			default:
			begin
				flags_d = flags_q;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			flags_q <= rsa_pkg::FLAGS_RST;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	// memory byte: mem_out keeps its last value between writes
	always_comb
	begin
		mem_d = mem_q;
		case (op_eff)
			rsa_pkg::RSA_OP_ROT_CARRY:
			begin
				mem_d = rot_right(carry_now, mem_in);
			end
			rsa_pkg::RSA_OP_SUB_MEM:
			begin
				mem_d = res.diff;
			end
			rsa_pkg::RSA_OP_ROT_ACC, rsa_pkg::RSA_OP_ROT_CARRY_ACC:
			begin
				mem_d = mem_q;
			end
			default:
			begin
				mem_d = mem_q;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mem_q <= rsa_pkg::MEM_RST;
		end
		else
		begin
			mem_q <= mem_d;
		end
	end

	// write strobe: one cycle per memory-bound operation, never for the acc forms
	always_comb
	begin
		we_d = 1'b0;
		if ((op_eff == rsa_pkg::RSA_OP_ROT_CARRY) || (op_eff == rsa_pkg::RSA_OP_SUB_MEM))
		begin
			we_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			we_q <= 1'b0;
		end
		else
		begin
			we_q <= we_d;
		end
	end

	assign acc_out = acc_q;
	assign flags_out = flags_q;
	assign mem_out = mem_q;
	assign mem_we_out = we_q;
endmodule

// ==== include/rsa_pkg.sv ====
/*
 package for the rotate / borrow-subtract alu slice.
 assumes an 8-bit core with the decoder giving a one-hot operation code.
*/
package rsa_pkg;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic [7:0] MEM_RST = 8'h00;
	// flag vector bit positions
	localparam int F_CARRY = 0;
	localparam int F_HALF = 1;
	localparam int F_ZERO = 2;
	localparam int F_WRAP = 3;
	localparam int F_CSIGN = 4;
	localparam int F_CNULL = 5;
	localparam int FLAG_W = 6;
	typedef enum logic [5:0]
	{
		RSA_OP_NONE = 6'h01,
		RSA_OP_ROT_ACC = 6'h02,
		RSA_OP_ROT_CARRY = 6'h04,
		RSA_OP_ROT_CARRY_ACC = 6'h08,
		RSA_OP_SUB_ACC = 6'h10,
		RSA_OP_SUB_MEM = 6'h20
	} rsa_op_t;
endpackage

// ==== include/rsa_res_if.sv ====
/*
 interface carrying the combinational result between core and compute unit.
 assumes both ends on the same clock.
*/
`timescale 1ns/100ps
interface rsa_res_if;
	logic [7:0] diff;
	logic carry;
	logic half;
	logic wrap;
	logic zero;
	modport calc (output diff, output carry, output half, output wrap, output zero);
	modport user (input diff, input carry, input half, input wrap, input zero);
endinterface

// ==== src/rsa_sub.sv ====
/*
 borrow subtractor: acc minus operand minus inverted carry, with flags.
 assumes operands stable within the cycle; purely combinational.
*/
`timescale 1ns/100ps
module rsa_sub
(
	input wire logic [7:0] acc_in,
	input wire logic [7:0] opd_in,
	input wire logic carry_in,
	rsa_res_if.calc res
);
	logic [8:0] full;
	logic [4:0] low;
	always_comb
	begin
		full = {1'b0, acc_in} - {1'b0, opd_in} - {8'h00, ~carry_in};
		low = {1'b0, acc_in[3:0]} - {1'b0, opd_in[3:0]} - {4'h0, ~carry_in};
		res.diff = full[7:0];
		// borrow out means negative: carry cleared, else set
		res.carry = ~full[8];
		res.half = ~low[4];
		res.wrap = (acc_in[7] ^ opd_in[7]) & (acc_in[7] ^ full[7]);
		res.zero = (full[7:0] == 8'h00);
	end
endmodule

// ==== test/rsa_props.sv ====
/*
 checker on the ports of rsa_core, bound into it below.
 assumes one clock and the async active-low reset of the core.
*/
`timescale 1ns/100ps
module rsa_props
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mem_we_out,
	input wire logic [5:0] op_in,
	input wire logic [5:0] flags_out,
	input wire logic [7:0] mem_in,
	input wire logic [7:0] acc_out,
	input wire logic [7:0] mem_out
);
	wire [8:0] d = {1'b1, acc_out} - mem_in - !flags_out[0];
	wire [7:0] r = {mem_in[0], mem_in[7:1]};
	wire [7:0] p = {flags_out[0], mem_in[7:1]};
	wire [4:0] h = {1'b1, acc_out[3:0]} - mem_in[3:0] - !flags_out[0];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_ra; $past(op_in) == 6'h02 |-> acc_out == $past(r); endproperty
	a_ra: assert property (p_ra) else $error("rot");
	property p_nf; $past(op_in) == 6'h02 |-> $stable(flags_out) && !mem_we_out; endproperty
	a_nf: assert property (p_nf) else $error("kept");
	property p_cm; $past(op_in) == 6'h04 |-> mem_we_out && mem_out == $past(p)
		&& flags_out == {$past(flags_out[5:1]), $past(mem_in[0])}; endproperty
	a_cm: assert property (p_cm) else $error("rcm");
	property p_ca; $past(op_in) == 6'h08 |-> acc_out == $past(p) && !mem_we_out; endproperty
	a_ca: assert property (p_ca) else $error("rca");
	property p_sa; $past(op_in) == 6'h10 |-> acc_out == $past(d[7:0]); endproperty
	a_sa: assert property (p_sa) else $error("sub");
	property p_sc; $past(op_in) inside {6'h10, 6'h20} |-> flags_out[0] == $past(d[8]); endproperty
	a_sc: assert property (p_sc) else $error("carry");
	property p_sf; $past(op_in) == 6'h10 |-> flags_out[2] == !acc_out
		&& flags_out[4] == (acc_out[7] ^ flags_out[3]) && flags_out[1] == $past(h[4])
		&& flags_out[5] == (flags_out[2] && $past(flags_out[5])); endproperty
	a_sf: assert property (p_sf) else $error("flags");
	property p_sm; $past(op_in) == 6'h20 |-> mem_we_out && mem_out == $past(d[7:0]); endproperty
	a_sm: assert property (p_sm) else $error("subm");
endmodule
bind rsa_core rsa_props u_chk (.clk_in, .rst_n_in, .mem_we_out, .op_in, .flags_out, .mem_in,
	.acc_out, .mem_out);

// ==== test/tb_top.sv ====
/*
 bench for rsa_core: random operations with 00 / FF corner bytes among them.
 assumes the checker in rsa_props is bound into the core for the same run.
*/
`timescale 1ns/100ps
module tb_top;
	logic clk_in = 0, rst_n_in = 0, w = 0;
	logic [5:0] op_in = 6'h01, flags_out, f = 6'h00;
	logic [7:0] mem_in = 8'h00, acc_out, mem_out, a = 8'h00, mo = 8'h00;
	logic mem_we_out;
	int n_mismatch = 0, n_checks = 0, n_cycles = 0;
	rsa_core uut (.clk_in, .rst_n_in, .op_in, .mem_in, .acc_out, .flags_out, .mem_out,
		.mem_we_out);
	always #25 clk_in = ~clk_in;
	// {cnull, csign, wrap, zero, half, carry} and the difference of a borrow subtract
	function automatic logic [13:0] sub_exp(input logic [7:0] x, input logic [7:0] y,
		input logic [5:0] fl);
		logic [8:0] s;
		logic [4:0] h;
		logic v;
		s = {1'b1, x} - {1'b0, y} - {8'h00, !fl[0]};
		h = {1'b1, x[3:0]} - {1'b0, y[3:0]} - {4'h0, !fl[0]};
		v = (x[7] != y[7]) && (s[7] != x[7]);
		return {((s[7:0] == 8'h00) && fl[5]), (s[7] ^ v), v, (s[7:0] == 8'h00), h[4], s[8], s[7:0]};
	endfunction
	task automatic report_and_stop;
		$display("errors %0d checks %0d", n_mismatch, n_checks);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_in)
	begin
		n_cycles++;
		n_checks++;
		if ({acc_out, flags_out} !== {a, f})
		begin
			n_mismatch++;
			$display("wrong value at %0t: acc or flags", $time);
		end
		n_checks++;
		if ({mem_we_out, mem_out} !== {w, mo})
		begin
			n_mismatch++;
			$display("wrong value at %0t: memory port", $time);
		end
		if (n_cycles > 900)
		begin
			n_mismatch++;
			$display("wrong value at %0t: timeout", $time);
			report_and_stop;
		end
		w = 1'b0;
		case (op_in)
			6'h02: a = {mem_in[0], mem_in[7:1]};
			6'h04: {mo, f[0], w} = {f[0], mem_in, 1'b1};
			6'h08: {a, f[0]} = {f[0], mem_in};
			6'h10: {f, a} = sub_exp(a, mem_in, f);
			6'h20: {f, mo, w} = {sub_exp(a, mem_in, f), 1'b1};
			default: ;
		endcase
	end
	initial
	begin
		void'($urandom(32'hE5633834));
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 800; i++)
		begin
			@(posedge clk_in);
			op_in <= 6'h01 << ($urandom % 7);
			mem_in <= (i % 8 != 0) ? 8'($urandom) : {8{i[3]}};
		end
		@(posedge clk_in);
		op_in <= 6'h01;
		repeat (3) @(posedge clk_in);
		report_and_stop;
	end
endmodule
